// ===== rtl/spc_pkg.sv
// spc_pkg: constants for the system pll control block.
// assumes a 32-bit apb slave with each register in one aligned word.
package spc_pkg;

  // register byte offsets
  localparam logic [11:0] SPC_OFF_CTRL    = 12'h008;
  localparam logic [11:0] SPC_OFF_STAT    = 12'h00c;
  localparam logic [11:0] SPC_OFF_SRCSEL  = 12'h040;
  localparam logic [11:0] SPC_OFF_PWRCFG  = 12'h238;

  // divider control fields
  localparam int          SPC_FB_LSB      = 0;
  localparam int          SPC_FB_W        = 5;
  localparam int          SPC_PSEL_LSB    = 5;
  localparam int          SPC_PSEL_W      = 2;
  localparam logic [6:0]  SPC_CTRL_RST    = 7'h00;

  // power configuration: bit 7 powers the pll down, low half word stored
  localparam int          SPC_PD_BIT      = 7;
  localparam int          SPC_PWRCFG_W    = 16;
  localparam logic [15:0] SPC_PWRCFG_RST  = 16'hed80;

  // reference source select
  localparam int          SPC_SRC_W       = 2;
  localparam int          SPC_NUM_SRC     = 4;
  localparam logic [1:0]  SPC_SRC_RST     = 2'h0;

  // status fields
  localparam int          SPC_STAT_LOCK   = 0;
  localparam int          SPC_STAT_CCO    = 1;

  // behavioural loop model
  localparam int          SPC_PER_W       = 16;
  localparam int          SPC_STEP_W      = 10;
  localparam logic [3:0]  SPC_LOCK_CNT    = 4'h9;
  localparam logic [SPC_PER_W-1:0] SPC_LOCK_TOL = 16'h0002;
  localparam logic [SPC_PER_W-1:0] SPC_PER_MAX  = 16'hffff;

  typedef enum logic [1:0] {
    SPC_ST_OFF     = 2'b00,
    SPC_ST_MEASURE = 2'b01,
    SPC_ST_TRACK   = 2'b10
  } spc_state_e;

endpackage

// ===== rtl/spc_system_pll.sv
// spc_system_pll: apb register file plus behavioural model of the system pll.
// assumes reference clocks arrive asynchronously and are far slower than clk;
// the modelled cco must not tick more than once per clk cycle.
//
// Operation
// - setting the pll power-down bit puts the pll into power-down, clearing it leaves.
// - in power-down the bias, oscillator and phase detector stop and both dividers reset.
// - the lock output is low throughout power-down.
// - after power-down is released the pll runs again and signals lock only once relocked.
// - the post divider divides by two times p, giving a 50% duty cycle output.
// - the output to reference ratio is the feedback divider select value plus one.
// - output frequency is m times reference and also oscillator over two times p.
// - the reference is taken from the pll source multiplexer output.
// - lock rises after more than eight good phase compares and drops on one bad one.
// - the power-down bit is bit 7 of the power configuration register, reset to 1.
`timescale 1ns/1ps
`default_nettype none

module spc_system_pll
  import spc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [SPC_NUM_SRC-1:0] ref_clk_in,
  output logic                        pll_clk_out,
  output logic                        pll_lock,
  output logic                        pll_power_down,
  output logic                        pll_bias_on,
  output logic                        pll_cco_run
);

  logic [SPC_PSEL_W+SPC_FB_W-1:0]   ctrl_ff;
  logic [SPC_PWRCFG_W-1:0]          pwrcfg_ff;
  logic [SPC_SRC_W-1:0]             srcsel_ff;
  logic [31:0]                      prdata_ff;
  logic                             pready_ff;
  logic                             pslverr_ff;

  logic [SPC_NUM_SRC-1:0]           ref_meta_ff;
  logic [SPC_NUM_SRC-1:0]           ref_sync_ff;
  logic                             ref_prev_ff;
  logic                             ref_edge;

  spc_state_e                       state_ff;
  spc_state_e                       nxt_state;
  logic [SPC_PER_W-1:0]             per_cnt_ff;
  logic [SPC_PER_W-1:0]             period_ff;
  logic [SPC_PER_W-1:0]             acc_ff;
  logic [SPC_PER_W-1:0]             nxt_acc;
  logic [SPC_PER_W:0]               acc_sum;
  logic                             cco_tick;
  logic                             tick_raw;
  logic [SPC_STEP_W-1:0]            step;
  logic [SPC_STEP_W-1:0]            p_val;
  logic [SPC_STEP_W-1:0]            m_val;
  logic [SPC_STEP_W-1:0]            post_cnt_ff;
  logic [SPC_STEP_W-1:0]            fb_cnt_ff;
  logic                             out_ff;
  logic                             out_fall;
  logic                             fb_pulse;
  logic [1:0]                       fb_seen_ff;
  logic [SPC_PER_W-1:0]             since_fb_ff;
  logic                             phase_good;
  logic                             realign;
  logic [3:0]                       good_cnt_ff;
  logic                             lock_ff;
  logic                             pd;
  logic                             nxt_pd;
  logic                             halt;
  logic                             bias_ff;
  logic                             cco_ff;

  logic                             access;
  logic                             wr_en;
  logic                             addr_hit;

  assign pd = pwrcfg_ff[SPC_PD_BIT];
  assign nxt_pd = (wr_en && paddr == SPC_OFF_PWRCFG) ? pwdata[SPC_PD_BIT] : pd;
  assign halt   = nxt_pd | (state_ff != SPC_ST_TRACK);

  assign access = psel & penable & ~pready_ff;
  assign wr_en  = psel & penable & pready_ff & pwrite;

  always_comb begin
    addr_hit = (paddr == SPC_OFF_CTRL) || (paddr == SPC_OFF_STAT) ||
               (paddr == SPC_OFF_SRCSEL) || (paddr == SPC_OFF_PWRCFG);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access & ~addr_hit;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (access & ~pwrite) begin
      case (paddr)
        SPC_OFF_CTRL:   prdata_ff <= {25'h0, ctrl_ff};
        SPC_OFF_STAT:   prdata_ff <= {30'h0, cco_ff, lock_ff};
        SPC_OFF_SRCSEL: prdata_ff <= {30'h0, srcsel_ff};
        SPC_OFF_PWRCFG: prdata_ff <= {16'h0, pwrcfg_ff};
        default:        prdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= SPC_CTRL_RST;
    end else if (wr_en && paddr == SPC_OFF_CTRL) begin
      ctrl_ff <= pwdata[SPC_PSEL_W+SPC_FB_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwrcfg_ff <= SPC_PWRCFG_RST;
    end else if (wr_en && paddr == SPC_OFF_PWRCFG) begin
      pwrcfg_ff <= pwdata[SPC_PWRCFG_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      srcsel_ff <= SPC_SRC_RST;
    end else if (wr_en && paddr == SPC_OFF_SRCSEL) begin
      srcsel_ff <= pwdata[SPC_SRC_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_meta_ff <= '0;
      ref_sync_ff <= '0;
    end else begin
      ref_meta_ff <= ref_clk_in;
      ref_sync_ff <= ref_meta_ff;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_prev_ff <= 1'b0;
    end else begin
      ref_prev_ff <= ref_sync_ff[srcsel_ff];
    end
  end

  assign ref_edge = ref_sync_ff[srcsel_ff] & ~ref_prev_ff & ~pd;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SPC_ST_OFF:     nxt_state = pd ? SPC_ST_OFF : SPC_ST_MEASURE;
      SPC_ST_MEASURE: nxt_state = ref_edge ? SPC_ST_TRACK : SPC_ST_MEASURE;
      SPC_ST_TRACK:   nxt_state = SPC_ST_TRACK;
      default:        nxt_state = SPC_ST_OFF;
    endcase
    if (pd) begin
      nxt_state = SPC_ST_OFF;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= SPC_ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reference period in clk cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      per_cnt_ff <= '0;
      period_ff  <= '0;
    end else if (pd) begin
      per_cnt_ff <= '0;
      period_ff  <= '0;
    end else if (ref_edge) begin
      per_cnt_ff <= 16'h0001;
      period_ff  <= per_cnt_ff;
    end else if (per_cnt_ff != SPC_PER_MAX) begin
      per_cnt_ff <= per_cnt_ff + 16'h0001;
    end
  end

  always_comb begin
    case (ctrl_ff[SPC_PSEL_LSB +: SPC_PSEL_W])
      2'h0:    p_val = 10'h001;
      2'h1:    p_val = 10'h002;
      2'h2:    p_val = 10'h004;
      default: p_val = 10'h008;
    endcase
    m_val = {5'h0, ctrl_ff[SPC_FB_LSB +: SPC_FB_W]} + 10'h001;
    step  = 10'((p_val * m_val) << 1);
  end

  assign realign  = ref_edge & ~phase_good & (state_ff == SPC_ST_TRACK);
  assign acc_sum  = {1'b0, acc_ff} + {7'h0, step};
  assign tick_raw = (state_ff == SPC_ST_TRACK) && (period_ff != '0) &&
                    (acc_sum >= {1'b0, period_ff});
  assign cco_tick = tick_raw && !realign;

  always_comb begin
    if (cco_tick) begin
      nxt_acc = 16'(acc_sum - {1'b0, period_ff});
    end else begin
      nxt_acc = acc_sum[SPC_PER_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_ff <= '0;
    end else if (halt || realign) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // post divider: toggle every p cco ticks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      post_cnt_ff <= '0;
      out_ff      <= 1'b0;
    end else if (halt || realign) begin
      post_cnt_ff <= '0;
      out_ff      <= 1'b0;
    end else if (cco_tick) begin
      if (post_cnt_ff == p_val - 10'h001) begin
        post_cnt_ff <= '0;
        out_ff      <= ~out_ff;
      end else begin
        post_cnt_ff <= post_cnt_ff + 10'h001;
      end
    end
  end

  assign out_fall = tick_raw && (post_cnt_ff == p_val - 10'h001) && out_ff;
  assign fb_pulse = out_fall && (fb_cnt_ff == m_val - 10'h001);

  // feedback divider: one pulse per m output periods
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fb_cnt_ff <= '0;
    end else if (halt || realign) begin
      fb_cnt_ff <= '0;
    end else if (out_fall) begin
      fb_cnt_ff <= fb_pulse ? 10'h000 : fb_cnt_ff + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fb_seen_ff  <= 2'h0;
      since_fb_ff <= '0;
    end else if (state_ff != SPC_ST_TRACK || ref_edge) begin
      fb_seen_ff  <= 2'h0;
      since_fb_ff <= SPC_PER_MAX;
    end else if (fb_pulse) begin
      fb_seen_ff  <= (fb_seen_ff == 2'h3) ? 2'h3 : fb_seen_ff + 2'h1;
      since_fb_ff <= '0;
    end else if (since_fb_ff != SPC_PER_MAX) begin
      since_fb_ff <= since_fb_ff + 16'h0001;
    end
  end

  // one feedback edge per reference period, close to the reference edge
  always_comb begin
    phase_good = (fb_seen_ff == 2'h1) && (since_fb_ff <= SPC_LOCK_TOL);
    if (fb_pulse) begin
      phase_good = (fb_seen_ff == 2'h0);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      good_cnt_ff <= '0;
      lock_ff     <= 1'b0;
    end else if (halt) begin
      good_cnt_ff <= '0;
      lock_ff     <= 1'b0;
    end else if (ref_edge) begin
      if (!phase_good) begin
        good_cnt_ff <= '0;
        lock_ff     <= 1'b0;
      end else if (good_cnt_ff != SPC_LOCK_CNT) begin
        good_cnt_ff <= good_cnt_ff + 4'h1;
        lock_ff     <= (good_cnt_ff + 4'h1 == SPC_LOCK_CNT);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bias_ff <= 1'b0;
      cco_ff  <= 1'b0;
    end else begin
      bias_ff <= ~pd;
      cco_ff  <= (nxt_state == SPC_ST_TRACK) & ~nxt_pd;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign pll_clk_out    = out_ff;
  assign pll_lock       = lock_ff;
  assign pll_power_down = pwrcfg_ff[SPC_PD_BIT];
  assign pll_bias_on    = bias_ff;
  assign pll_cco_run    = cco_ff;

endmodule

`default_nettype wire

// ===== tb/spc_ref_model.sv
// spc_ref_model: free running reference clocks for the pll source mux.
// assumes a 20 ns system clock; edges never coincide with its rising edge.
`timescale 1ns/1ps
`default_nettype none

module spc_ref_model
(
  output logic [3:0] ref_clk
);
  int unsigned tick;

  // input i has period 40*(i+1) clk, at least 2*p*m for every used setting
  initial begin
    ref_clk = 4'h0;
    tick    = 0;
    forever begin
      #400;
      tick++;
      for (int i = 0; i < 4; i++) begin
        if (tick % (i + 1) == 0) begin
          ref_clk[i] = ~ref_clk[i];
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/spc_system_pll_props.sv
// spc_system_pll_props: port checks for the system pll block.
// assumes it is bound onto spc_system_pll with one clock domain.
`timescale 1ns/1ps
`default_nettype none

module spc_system_pll_props
  import spc_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic [11:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [SPC_NUM_SRC-1:0] ref_clk_in,
  input wire logic                   pll_clk_out,
  input wire logic                   pll_lock,
  input wire logic                   pll_power_down,
  input wire logic                   pll_bias_on,
  input wire logic                   pll_cco_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic acc = psel & penable;

  ready_wait_a: assert property ($rose(acc) |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray rdata");
  pd_write_a: assert property (acc && pready && pwrite && paddr == SPC_OFF_PWRCFG
    |=> pll_power_down == $past(pwdata[SPC_PD_BIT])) else $error("pd bit wrong");
  pd_lock_low_a: assert property (pll_power_down |-> !pll_lock) else $error("lock in pd");
  pd_stop_a: assert property (pll_power_down && $past(pll_power_down)
    |-> !pll_cco_run && !pll_clk_out) else $error("running in pd");
  bias_track_a: assert property (pll_bias_on == !$past(pll_power_down))
    else $error("bias wrong");
  lock_late_a: assert property ($rose(pll_lock) |-> $past(pll_power_down, 16) == 1'b0)
    else $error("lock too early");

  cover property ($rose(pll_lock));
  cover property (pslverr);
  cover property ($rose(pll_clk_out));
endmodule

bind spc_system_pll spc_system_pll_props u_props (.clk(clk), .reset(reset), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in), .pll_clk_out(pll_clk_out),
  .pll_lock(pll_lock), .pll_power_down(pll_power_down), .pll_bias_on(pll_bias_on),
  .pll_cco_run(pll_cco_run));

`default_nettype wire

// ===== tb/system_pll_control_tb.sv
// system_pll_control_tb: register and loop tests for the system pll block.
// assumes spc_ref_model supplies the reference clocks.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module system_pll_control_tb
  import spc_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} spc_row_s;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic [3:0]  ref_clk;
  logic        pll_clk_out, pll_lock, pll_power_down, pll_bias_on, pll_cco_run;
  int          fail_count, samples_checked, cycles;
  spc_row_s    rows [5] = '{'{12'h008, 32'h0000ffff, 32'h0000007f, 1'b0},
                            '{12'h040, 32'hffffffff, 32'h00000003, 1'b0},
                            '{12'h238, 32'h0001ed80, 32'h0000ed80, 1'b0},
                            '{12'h00c, 32'hffffffff, 32'h00000000, 1'b0},
                            '{12'h100, 32'h12345678, 32'h00000000, 1'b1}};

  always #10 clk = ~clk;

  spc_ref_model u_ref (.ref_clk(ref_clk));

  spc_system_pll DUT (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_in(ref_clk), .pll_clk_out(pll_clk_out), .pll_lock(pll_lock),
    .pll_power_down(pll_power_down), .pll_bias_on(pll_bias_on), .pll_cco_run(pll_cco_run));

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cfg(input logic [6:0] ctrl, input logic [1:0] src, input int rises);
    int n, hi, up;
    logic prev;
    apb(SPC_OFF_PWRCFG, 32'h0000ed80, 1'b1, rd, er);
    @(negedge clk);
    `CHK({pll_lock, pll_cco_run, pll_clk_out}, 3'b000)
    apb(SPC_OFF_CTRL, {25'h0, ctrl}, 1'b1, rd, er);
    apb(SPC_OFF_SRCSEL, {30'h0, src}, 1'b1, rd, er);
    apb(SPC_OFF_PWRCFG, 32'h0000ed00, 1'b1, rd, er);
    n = 0;
    while (pll_lock !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK({pll_lock, pll_bias_on}, 2'b11)
    hi = 0;
    up = 0;
    prev = pll_clk_out;
    repeat (160) begin
      @(negedge clk);
      hi += int'(pll_clk_out === 1'b1);
      up += int'(pll_clk_out === 1'b1 && prev === 1'b0);
      prev = pll_clk_out;
    end
    `CHK(up, rises)
    `CHK(hi, 80)
    apb(SPC_OFF_STAT, 32'h0, 1'b0, rd, er);
    `CHK(rd, 32'h00000003)
    $display("config %0h src %0d done", ctrl, src);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, 1'b1, rd, er);
      apb(rows[i].a, 32'h0, 1'b0, rd, er);
      `CHK({rd, er}, {rows[i].r, rows[i].e})
      $display("row %0d done", i);
    end
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    apb(SPC_OFF_PWRCFG, 32'h0, 1'b0, rd, er);
    `CHK(rd, 32'h0000ed80)
    apb(SPC_OFF_CTRL, 32'h0, 1'b0, rd, er);
    `CHK({rd, pll_power_down, pll_bias_on}, {32'h0, 1'b1, 1'b0})
    $display("reset test done");
    run_cfg(7'h41, 2'h0, 8);
    run_cfg(7'h24, 2'h1, 10);
    run_cfg(7'h24, 2'h0, 20);
    apb(SPC_OFF_SRCSEL, 32'h1, 1'b1, rd, er);
    repeat (200) @(negedge clk);
    `CHK(pll_lock, 1'b0)
    $display("lock drop test done");
    finish_test();
  end
endmodule

`default_nettype wire
